//--- ssp_master.sv
/* ssp_master: mode 0 master model for the serial port pins.
   Assumes the caller picks a bit rate the port accepts. */
`timescale 1ns/1ps
`default_nettype none
// ======
// master
// ======
module ssp_master
(
	// pins toward the port
	output var logic o_sck,
	output var logic o_nss_b,
	output var logic o_mosi,
	input wire logic i_miso,
	input wire logic i_miso_oe_b
);
	logic line;
	// released line reads inverted so stale data never matches
	assign line = i_miso_oe_b ? ~i_miso : i_miso;
	initial
	begin
		o_sck = 1'b0;
		o_nss_b = 1'b1;
		o_mosi = 1'b0;
	end
	// n bits msb first, half period h; sel low keeps select idle
	task automatic frame(input logic [15:0] tx, input int n, input int h,
		input logic sel, output logic [15:0] rx);
		rx = 16'h0000;
		o_nss_b <= !sel;
		#(h);
		for (int i = 15; i > 15 - n; i--)
		begin
			o_mosi <= tx[i];
			#(h);
			o_sck <= 1'b1;
			rx[i] = line;
			#(h);
			o_sck <= 1'b0;
		end
		#(h);
		o_nss_b <= 1'b1;
		o_mosi <= ~o_mosi;
		#(4 * h);
	endtask : frame
endmodule : ssp_master
`default_nettype wire

//--- ssp_pkg.sv
/*
 * ssp_pkg: constants and carrier types for the serial register port.
 * Assumes a single 125 MHz system clock; pin levels enter asynchronously.
 */
// ============================================================
// package
// ============================================================
package ssp_pkg;
	// data width of one serial word
	localparam int unsigned BYTE_W = 8;
	// system clock period in ns and the select-to-output limits in periods
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned MISO_VALID_T = 4;
	localparam int unsigned MISO_HIZ_T = 4;
	// synchroniser depth: two flip-flops before any logic reads a pin
	localparam int unsigned SYNC_STAGES = 2;
	// reset values
	localparam logic [7:0] SHIFT_RST = 8'h00;
	localparam logic [2:0] BITCNT_RST = 3'h0;

	// synchronised pin levels
	typedef struct packed {
		logic sck;
		logic nss_b;
		logic mosi;
	} ssp_pins_t;

	// frame state, gray coded along idle -> active -> ending
	typedef enum logic [1:0] {
		SSP_IDLE   = 2'b00,
		SSP_ACTIVE = 2'b01,
		SSP_ENDING = 2'b11
	} ssp_state_t;
endpackage : ssp_pkg

//--- ssp_port.sv
/*
 * ssp_port: mode 0 serial slave port that moves bytes between an external
 * master and the register/RAM logic behind it.
 * Assumes the master keeps the bit rate and select set-up/hold limits in
 * system clock periods; the byte protocol lives in the user-side logic.
 */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// serial port
// ============================================================
// Function
// RQ1: input line shifted in, MSB first
// RQ2: output line driven, MSB first
// RQ3: output tristated while select inactive
// RQ4: clock ignored while select inactive
// RQ5: select fall starts, rise ends transfer
// RQ6: master uses mode 0
// RQ7: full-duplex rate at most tenth clock
// RQ8: asynchronous master stays below tenth clock
// RQ9: write-only accepted up to quarter clock
// RQ10: master waits two periods before clock
// RQ11: master waits two periods before deselect
// RQ12: output valid within four periods
// RQ13: output released within four periods
// RQ14: sample rising edge, shift falling edge
// RQ15: inputs synchronised, edges detected internally
module ssp_port
(
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	// serial pins
	input  wire logic             i_sck,
	input  wire logic             i_nss_b,
	input  wire logic             i_mosi,
	output logic                  o_miso,
	output logic                  o_miso_oe_b,
	// user side: byte to send, loaded at frame start and after each byte
	input  wire logic [7:0]       i_tx_data,
	output logic                  o_tx_load,
	// user side: received byte
	output logic [7:0]            o_rx_data,
	output logic                  o_rx_valid,
	// user side: frame markers
	output logic                  o_frame_start,
	output logic                  o_frame_end,
	output logic                  o_busy
);
	ssp_pkg::ssp_pins_t pins_raw;
	ssp_pkg::ssp_pins_t pins_s;
	ssp_pkg::ssp_pins_t pins_q_reg;
	ssp_pkg::ssp_state_t state_reg;
	ssp_pkg::ssp_state_t state_next;
	logic [7:0] rx_sh_reg;
	logic [7:0] rx_sh_next;
	logic [7:0] tx_sh_reg;
	logic [7:0] tx_sh_next;
	logic [2:0] bit_reg;
	logic [2:0] bit_next;
	logic [7:0] rx_data_reg;
	logic [7:0] rx_data_next;
	logic       rx_valid_reg;
	logic       rx_valid_next;
	logic       miso_reg;
	logic       miso_next;
	logic       oe_b_reg;
	logic       oe_b_next;
	logic       sck_rise;
	logic       sck_fall;
	logic       nss_fall;
	logic       nss_rise;
	logic       load;

	// shift one bit in at the bottom; both shift registers move this way
	function automatic logic [7:0] shift_in(input logic [7:0] value,
		input logic fill);
		shift_in = {value[6:0], fill};
	endfunction : shift_in

	// raw pin levels gathered into one carrier before the synchroniser
	assign pins_raw = '{sck: i_sck, nss_b: i_nss_b, mosi: i_mosi};

	// pins cross into i_clk before anything looks at them
	ssp_sync u_sync
	(
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_pins  (pins_raw),
		.o_pins  (pins_s)
	); // RQ15

	// one delayed copy of the synchronised levels for edge detection
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			pins_q_reg <= '{sck: 1'b0, nss_b: 1'b1, mosi: 1'b0};
		else
			pins_q_reg <= pins_s;
	end

	// edges; clock edges only count inside a frame
	always_comb
	begin
		nss_fall = pins_q_reg.nss_b & ~pins_s.nss_b; // RQ5
		nss_rise = ~pins_q_reg.nss_b & pins_s.nss_b; // RQ5
		sck_rise = ~pins_q_reg.sck & pins_s.sck & ~pins_s.nss_b; // RQ4 RQ14
		sck_fall = pins_q_reg.sck & ~pins_s.sck & ~pins_s.nss_b; // RQ4 RQ14
	end

	// a fresh byte is fetched at frame start and after every eighth bit
	assign load = nss_fall | (sck_fall && (bit_reg == ssp_pkg::BITCNT_RST)
		&& (state_reg == ssp_pkg::SSP_ACTIVE));

	// next-state and datapath; output timing is 3 periods from the pin
	// edge (2 sync + 1 register), inside the 4 period limit
	always_comb
	begin
		state_next    = state_reg;
		rx_sh_next    = rx_sh_reg;
		tx_sh_next    = tx_sh_reg;
		bit_next      = bit_reg;
		rx_data_next  = rx_data_reg;
		rx_valid_next = 1'b0;
		miso_next     = miso_reg;
		oe_b_next     = oe_b_reg;
		case (state_reg)
			ssp_pkg::SSP_IDLE:
			begin
				oe_b_next = 1'b1; // RQ3
				if (nss_fall)
				begin
					state_next = ssp_pkg::SSP_ACTIVE;
					bit_next   = ssp_pkg::BITCNT_RST;
					rx_sh_next = ssp_pkg::SHIFT_RST;
					tx_sh_next = shift_in(i_tx_data, 1'b0);
					miso_next  = i_tx_data[7]; // RQ2 RQ14
					oe_b_next  = 1'b0; // RQ12
				end
			end
			ssp_pkg::SSP_ACTIVE:
			begin
				if (nss_rise)
				begin
					state_next = ssp_pkg::SSP_ENDING;
					oe_b_next  = 1'b1; // RQ13
				end
				else
				begin
					if (sck_rise)
					begin
						// sample on rising edge
						rx_sh_next = shift_in(rx_sh_reg, pins_s.mosi); // RQ1
						bit_next   = bit_reg + 3'h1;
						if (bit_reg == 3'h7)
						begin
							rx_data_next  = shift_in(rx_sh_reg, pins_s.mosi);
							rx_valid_next = 1'b1; // RQ9
						end
					end
					if (sck_fall)
					begin
						// shift out on falling edge, MSB first
						if (bit_reg == ssp_pkg::BITCNT_RST)
						begin
							miso_next  = i_tx_data[7];
							tx_sh_next = shift_in(i_tx_data, 1'b0);
						end
						else
						begin
							miso_next  = tx_sh_reg[7]; // RQ2 RQ14
							tx_sh_next = shift_in(tx_sh_reg, 1'b0);
						end
					end
				end
			end
			ssp_pkg::SSP_ENDING:
			begin
				// one cycle to announce the end, then idle
				oe_b_next  = 1'b1;
				state_next = ssp_pkg::SSP_IDLE;
			end
			default:
			begin
				state_next = ssp_pkg::SSP_IDLE;
				oe_b_next  = 1'b1;
			end
		endcase
	end

	// registers only
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_reg    <= ssp_pkg::SSP_IDLE;
			rx_sh_reg    <= ssp_pkg::SHIFT_RST;
			tx_sh_reg    <= ssp_pkg::SHIFT_RST;
			bit_reg      <= ssp_pkg::BITCNT_RST;
			rx_data_reg  <= ssp_pkg::SHIFT_RST;
			rx_valid_reg <= 1'b0;
			miso_reg     <= 1'b0;
			oe_b_reg     <= 1'b1;
		end
		else
		begin
			state_reg    <= state_next;
			rx_sh_reg    <= rx_sh_next;
			tx_sh_reg    <= tx_sh_next;
			bit_reg      <= bit_next;
			rx_data_reg  <= rx_data_next;
			rx_valid_reg <= rx_valid_next;
			miso_reg     <= miso_next;
			oe_b_reg     <= oe_b_next;
		end
	end

	// outputs; a limitation: transmit byte must be ready when load pulses
	assign o_miso        = miso_reg;
	assign o_miso_oe_b   = oe_b_reg; // RQ3
	assign o_rx_data     = rx_data_reg;
	assign o_rx_valid    = rx_valid_reg;
	assign o_tx_load     = load;
	assign o_frame_start = nss_fall;
	assign o_frame_end   = (state_reg == ssp_pkg::SSP_ENDING);
	assign o_busy        = (state_reg == ssp_pkg::SSP_ACTIVE);
endmodule : ssp_port
`default_nettype wire

//--- ssp_port_asserts.sv
/* ssp_port_asserts: pin and pulse checks for ssp_port.
   Assumes it is bound to ssp_port and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
// ======
// checker
// ======
module ssp_port_asserts
(
	// clock, reset, pins
	input wire logic       i_clk,
	input wire logic       i_rst_b,
	input wire logic       i_sck,
	input wire logic       i_nss_b,
	input wire logic       i_mosi,
	input wire logic       o_miso,
	input wire logic       o_miso_oe_b,
	// user side
	input wire logic [7:0] i_tx_data,
	input wire logic       o_tx_load,
	input wire logic [7:0] o_rx_data,
	input wire logic       o_rx_valid,
	input wire logic       o_frame_start,
	input wire logic       o_frame_end,
	input wire logic       o_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// select edges count from the first clock that samples them
	a_hiz_idle: assert property (i_nss_b[*6] |-> o_miso_oe_b)
		else $error("output driven while deselected");
	a_sck_ignored: assert property (i_nss_b[*6] |-> !o_busy && !o_rx_valid)
		else $error("activity while deselected");
	a_drive_by4: assert property
		($fell(i_nss_b) ##0 !i_nss_b[*5] |-> !o_miso_oe_b)
		else $error("output not driven in time");
	a_release_by4: assert property
		($rose(i_nss_b) ##0 i_nss_b[*5] |-> o_miso_oe_b)
		else $error("output not released in time");
	// start pulse stands only on the third sample of a low select
	a_start_mark: assert property
		($fell(i_nss_b) ##0 !i_nss_b[*3] |-> o_frame_start)
		else $error("frame start missing");
	// end pulse stands only on the fourth sample of a high select
	a_end_mark: assert property
		($rose(i_nss_b) ##0 i_nss_b[*4] |-> o_frame_end)
		else $error("frame end missing");
	a_busy_frame: assert property (o_frame_start |=> o_busy)
		else $error("busy not raised");
	a_byte_pulse: assert property (o_rx_valid |=> !o_rx_valid)
		else $error("byte pulse too long");
	c_byte: cover property (o_rx_valid);
	c_end: cover property (o_frame_end);
	c_reload: cover property (o_tx_load && !o_frame_start);
endmodule : ssp_port_asserts
`default_nettype wire

//--- ssp_sync.sv
/*
 * ssp_sync: two-flop synchronisers for the serial pins.
 * Assumes pins are asynchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// synchroniser
// ============================================================
module ssp_sync
(
	// clock and reset
	input  wire logic            i_clk,
	input  wire logic            i_rst_b,
	// raw pins
	input  wire ssp_pkg::ssp_pins_t i_pins,
	// synchronised levels
	output var  ssp_pkg::ssp_pins_t o_pins
);
	ssp_pkg::ssp_pins_t meta_reg;
	ssp_pkg::ssp_pins_t meta_next;
	ssp_pkg::ssp_pins_t sync_reg;
	ssp_pkg::ssp_pins_t sync_next;

	// next values: first stage feeds only the second
	always_comb
	begin
		meta_next = i_pins;
		sync_next = meta_reg;
	end

	// select resets high so no frame is seen at start-up
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meta_reg <= '{sck: 1'b0, nss_b: 1'b1, mosi: 1'b0};
			sync_reg <= '{sck: 1'b0, nss_b: 1'b1, mosi: 1'b0};
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_pins = sync_reg;
endmodule : ssp_sync
`default_nettype wire

//--- test_ssp_port.sv
/* test_ssp_port: directed frames through the serial port.
   Assumes ssp_master and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench
// ============================================================
module test_ssp_port;
	logic        i_clk, i_rst_b, i_sck, i_nss_b, i_mosi;
	logic        o_miso, o_miso_oe_b, o_tx_load, o_rx_valid;
	logic        o_frame_start, o_frame_end, o_busy;
	// transmit byte starts at A5 and only the user model below moves it
	logic [7:0]  i_tx_data = 8'hA5;
	logic [7:0]  o_rx_data;
	logic [15:0] got = 16'h0000;
	logic [15:0] rx;
	int          mismatches, samples_checked, nrx, cycles;
	ssp_port dut (.*);
	ssp_master m (.o_sck(i_sck), .o_nss_b(i_nss_b), .o_mosi(i_mosi),
		.i_miso(o_miso), .i_miso_oe_b(o_miso_oe_b));
	initial
	begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// user side: byte steps on each load, received bytes collected
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (o_tx_load)
			i_tx_data <= i_tx_data + 8'h11;
		if (o_rx_valid)
			got <= {got[7:0], o_rx_data};
		if (o_rx_valid)
			nrx <= nrx + 1;
		// all frames take under 800 cycles; ceiling leaves ample margin
		if (cycles == 4000)
		begin
			mismatches++;
			finish_test();
		end
	end
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// duplex at 96 ns a bit: bytes both ways, reload between them
	task automatic t_duplex;
		int n0;
		n0 = nrx;
		// first frame of the run, so the byte to send is still A5
		m.frame(16'h3CC3, 16, 48, 1'b1, rx);
		check("mosi bytes", got, 16'h3CC3);
		check("miso bytes", rx, 16'hA5B6);
		check("byte count", 16'(nrx - n0), 16'h0002);
	endtask : t_duplex
	// write only at the 64 ns link rate
	task automatic t_fast;
		m.frame(16'h5A81, 16, 32, 1'b1, rx);
		check("fast bytes", got, 16'h5A81);
	endtask : t_fast
	// clock toggles with select idle, then a cut byte and a whole one
	task automatic t_idle_cut;
		int n0;
		n0 = nrx;
		m.frame(16'hFFFF, 16, 32, 1'b0, rx);
		check("idle count", 16'(nrx - n0), 16'h0000);
		check("idle oe", {15'h0000, o_miso_oe_b}, 16'h0001);
		m.frame(16'hF800, 5, 48, 1'b1, rx);
		m.frame(16'h9600, 8, 48, 1'b1, rx);
		check("cut count", 16'(nrx - n0), 16'h0001);
		check("cut byte", {8'h00, got[7:0]}, 16'h0096);
	endtask : t_idle_cut
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	initial
	begin
		i_rst_b = 1'b0;
		repeat (16) @(posedge i_clk);
		i_rst_b <= 1'b1;
		#3;
		t_duplex();
		t_fast();
		t_idle_cut();
		finish_test();
	end
endmodule : test_ssp_port
bind ssp_port ssp_port_asserts chk (.*);
`default_nettype wire
